// File: rtl/drive_input_function_select.sv
// Discrete input function select for a pulse-commanded servo drive.
// Assumes inputs synchronous to clk and a classic Wishbone master.
//
// Function
// - Gear select bits pick one of four numerators.
// - Pulse block asserted discards pulses in position mode.
// - Pulse block deasserted accepts pulses in position mode.
// - Homing starts only on trigger rising edge.
// - Homing runs the configured method.
// - Channel select input chooses pulse channel.
// - Select low takes high-speed channel.
// - Select high takes low-speed channel.
// - Channel select mappable to any of nine inputs.
// - Mapped select overrides static channel choice.
`timescale 1ns/10ps
module drive_input_function_select (
  input  wire logic        clk,           // 100 MHz clock
  input  wire logic        rst,           // Synchronous, active high
  input  wire logic [8:0]  genInputs,     // General inputs, bit 0 is the first
  input  wire logic        hsPulse,       // High-speed channel pulse strobe
  input  wire logic        hsDir,         // High-speed channel direction, 1 reverse
  input  wire logic        lsPulse,       // Low-speed channel pulse strobe
  input  wire logic        lsDir,         // Low-speed channel direction
  input  wire logic        wb_cyc_i,      // Wishbone cycle
  input  wire logic        wb_stb_i,      // Wishbone strobe
  input  wire logic        wb_we_i,       // Wishbone write
  input  wire logic [7:0]  wb_adr_i,      // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,      // Wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,      // Wishbone write data
  output logic      [31:0] wb_dat_o,      // Wishbone read data
  output logic             wb_ack_o,      // Wishbone acknowledge
  output logic             homeStart,     // One-cycle homing launch
  output logic      [3:0]  homeMethod,    // Method latched at launch
  output logic             lowSpeedSel,   // 1 when low-speed channel in use
  output logic      [1:0]  gearIndex,     // Selected numerator index
  output logic      [31:0] posDemand      // Accumulated position demand
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]  ctrl;      // Control
    logic [19:0] map;       // Input mapping
    logic [63:0] num;       // Four numerators
    logic [15:0] den;       // Denominator
    logic [31:0] rem;       // Unsigned gear remainder
    logic [31:0] demand;    // Position demand
    logic        homePrev;  // Trigger level last cycle
    logic        homeGo;    // Launch pulse
    logic [3:0]  method;    // Launched method
    logic        lowSel;    // Channel in use
    logic [1:0]  gear;      // Numerator index
    logic [15:0] hcount;    // Homing launches
    logic [31:0] rdata;     // Read data
    logic        ack;       // Bus ack
  } state_t;

  state_t st_r;   // Registered state
  state_t st_nxt; // Next state

  // Pick one general input by index; out-of-range reads as low
  function automatic logic pick(input logic [8:0] ins, input logic [3:0] idx);
    pick = (idx < 4'h9) ? ins[idx] : 1'b0;
  endfunction : pick

  logic        gearLsb;          // gear_select_lsb level
  logic        gearMsb;          // gear_select_msb level
  logic        pulseCmdBlock;    // pulse_command_block level
  logic        homingTrigger;    // homing_trigger level
  logic        chanSelIn;        // Mapped channel select level
  logic        pulseStb;         // Pulse from chosen channel
  logic        pulseDir;         // Direction from chosen channel
  logic [15:0] curNum;           // Selected numerator
  logic [31:0] sum;              // Remainder plus scaled step
  logic [31:0] wmask;            // Byte-lane write mask
  logic        busReq;           // New bus request
  logic [31:0] denOnce;          // Denominator widened to the demand width
  logic [31:0] denTwice;         // Twice the denominator
  logic        twoSteps;         // Remainder covers two denominators
  logic [31:0] stepSize;         // Counts moved by this pulse

  // ****************************************
  // Input decode and gear arithmetic
  // ****************************************
  always_comb begin
    gearLsb       = pick(genInputs, st_r.map[dinsel_pkg::MAP_GEAR0+:4]);
    gearMsb       = pick(genInputs, st_r.map[dinsel_pkg::MAP_GEAR1+:4]);
    pulseCmdBlock = pick(genInputs, st_r.map[dinsel_pkg::MAP_BLOCK+:4]);
    homingTrigger = pick(genInputs, st_r.map[dinsel_pkg::MAP_HOME+:4]);
    // Any of the nine inputs may carry channel select
    chanSelIn     = pick(genInputs, st_r.map[dinsel_pkg::MAP_CHSEL+:4]);
    // Channel choice is registered so the pulse path uses last cycle's choice
    pulseStb      = st_r.lowSel ? lsPulse : hsPulse;
    pulseDir      = st_r.lowSel ? lsDir : hsDir;
    curNum        = st_r.num[{st_r.gear, 4'h0}+:16];
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    busReq = wb_cyc_i && wb_stb_i && !st_r.ack;
    sum = st_r.rem + {16'h0000, curNum};
    denOnce  = {16'h0000, st_r.den};
    denTwice = {15'h0000, st_r.den, 1'b0};
    // Ratios above two saturate at two counts per pulse; keeps the adder short
    twoSteps = (sum >= denTwice);
    stepSize = twoSteps ? 32'h0000_0002 : 32'h0000_0001;
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.homeGo = 1'b0;
    st_nxt.ack = 1'b0;
    // Gear bits are plain levels sampled every clock
    st_nxt.gear = {gearMsb, gearLsb};
    // Mapped input wins; static choice only when unmapped
    if (st_r.ctrl[dinsel_pkg::CTRL_SELMAP]) begin
      st_nxt.lowSel = chanSelIn;
    end else begin
      st_nxt.lowSel = st_r.ctrl[dinsel_pkg::CTRL_STATCH];
    end
    // Rising edge only; held level does not relaunch
    st_nxt.homePrev = homingTrigger;
    if (homingTrigger && !st_r.homePrev) begin
      st_nxt.homeGo = 1'b1;
      st_nxt.method = st_r.ctrl[dinsel_pkg::CTRL_METHOD+:4];
      st_nxt.hcount = st_r.hcount + 16'h0001;
    end
    // Accept pulses only in position mode with block low
    if (st_r.ctrl[dinsel_pkg::CTRL_POSMODE] && !pulseCmdBlock && pulseStb) begin
      // Remainder carries the fraction so no count is lost between pulses
      if (sum >= denOnce && st_r.den != 16'h0000) begin
        st_nxt.rem = twoSteps ? (sum - denTwice) : (sum - denOnce);
        if (pulseDir) begin
          // Reverse direction counts down
          st_nxt.demand = st_r.demand - stepSize;
        end else begin
          // Forward direction counts up
          st_nxt.demand = st_r.demand + stepSize;
        end
      end else begin
        // Fraction only: no count this pulse
        st_nxt.rem = sum;
      end
    end
    // Wishbone slave: one-cycle ack, writes land at the ack edge
    if (busReq) begin
      st_nxt.ack = 1'b1;
      st_nxt.rdata = 32'h0000_0000;
      if (wb_adr_i == dinsel_pkg::CTRL_OFS) begin
        // Control: mode, mapping, static channel, homing method
        st_nxt.rdata = {24'h0, st_r.ctrl};
        if (wb_we_i) begin
          st_nxt.ctrl = (st_r.ctrl & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
        end
      end else if (wb_adr_i == dinsel_pkg::MAP_OFS) begin
        // Input index for each function
        st_nxt.rdata = {12'h0, st_r.map};
        if (wb_we_i) begin
          st_nxt.map = (st_r.map & ~wmask[19:0]) | (wb_dat_i[19:0] & wmask[19:0]);
        end
      end else if (wb_adr_i == dinsel_pkg::NUM0_OFS) begin
        // First numerator
        st_nxt.rdata = {16'h0, st_r.num[15:0]};
        if (wb_we_i) begin
          st_nxt.num[15:0] = (st_r.num[15:0] & ~wmask[15:0])
                             | (wb_dat_i[15:0] & wmask[15:0]);
        end
      end else if (wb_adr_i == dinsel_pkg::NUM1_OFS) begin
        // Second numerator
        st_nxt.rdata = {16'h0, st_r.num[31:16]};
        if (wb_we_i) begin
          st_nxt.num[31:16] = (st_r.num[31:16] & ~wmask[15:0])
                              | (wb_dat_i[15:0] & wmask[15:0]);
        end
      end else if (wb_adr_i == dinsel_pkg::NUM2_OFS) begin
        // Third numerator
        st_nxt.rdata = {16'h0, st_r.num[47:32]};
        if (wb_we_i) begin
          st_nxt.num[47:32] = (st_r.num[47:32] & ~wmask[15:0])
                              | (wb_dat_i[15:0] & wmask[15:0]);
        end
      end else if (wb_adr_i == dinsel_pkg::NUM3_OFS) begin
        // Fourth numerator
        st_nxt.rdata = {16'h0, st_r.num[63:48]};
        if (wb_we_i) begin
          st_nxt.num[63:48] = (st_r.num[63:48] & ~wmask[15:0])
                              | (wb_dat_i[15:0] & wmask[15:0]);
        end
      end else if (wb_adr_i == dinsel_pkg::DEN_OFS) begin
        // Denominator; zero stops all demand counting
        st_nxt.rdata = {16'h0, st_r.den};
        if (wb_we_i) begin
          st_nxt.den = (st_r.den & ~wmask[15:0])
                       | (wb_dat_i[15:0] & wmask[15:0]);
        end
      end else if (wb_adr_i == dinsel_pkg::STAT_OFS) begin
        // Live status, read-only
        st_nxt.rdata = {24'h0, st_r.method, st_r.gear, st_r.lowSel, st_r.homePrev};
      end else if (wb_adr_i == dinsel_pkg::DEMAND_OFS) begin
        // Position demand, read-only
        st_nxt.rdata = st_r.demand;
      end else if (wb_adr_i == dinsel_pkg::HCOUNT_OFS) begin
        // Homing launch count, read-only
        st_nxt.rdata = {16'h0, st_r.hcount};
      end else begin
        // Unmapped offsets answer with zero and ignore writes
        st_nxt.rdata = 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{ctrl: dinsel_pkg::CTRL_RST, map: dinsel_pkg::MAP_RST,
                num: {4{dinsel_pkg::NUM_RST}}, den: dinsel_pkg::DEN_RST,
                default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o    = st_r.rdata;
  assign wb_ack_o    = st_r.ack;
  assign homeStart   = st_r.homeGo;
  assign homeMethod  = st_r.method;
  assign lowSpeedSel = st_r.lowSel;
  assign gearIndex   = st_r.gear;
  assign posDemand   = st_r.demand;

  // ****************************************
  // Assertions
  // ****************************************
  // Launch only where the trigger was low, then high
  a_home_edge: assert property (@(posedge clk) disable iff (rst)
    homeStart |-> $past(st_r.homePrev) == 1'b0 && st_r.homePrev)
    else $error("homing launched without a rising edge");
  // Method comes from the configuration at launch
  a_home_method: assert property (@(posedge clk) disable iff (rst)
    homeStart |-> homeMethod == $past(st_r.ctrl[7:4]))
    else $error("homing method not taken from configuration");
  // A launch is never two cycles long
  a_no_retrigger: assert property (@(posedge clk) disable iff (rst)
    homeStart |=> !homeStart)
    else $error("homing launched twice in a row");
  // A trigger held high does not launch again
  a_home_level: assert property (@(posedge clk) disable iff (rst)
    (homingTrigger && st_r.homePrev) |=> !homeStart)
    else $error("held trigger relaunched homing");
  // Every launch bumps the count by one
  a_home_count: assert property (@(posedge clk) disable iff (rst)
    homeStart |-> st_r.hcount == $past(st_r.hcount) + 16'h0001)
    else $error("homing count did not follow launch");
  // Blocked pulses leave the demand alone
  a_block_hold: assert property (@(posedge clk) disable iff (rst)
    pulseCmdBlock |=> $stable(posDemand))
    else $error("demand moved while pulses blocked");
  // Outside position mode pulses are dropped too
  a_mode_hold: assert property (@(posedge clk) disable iff (rst)
    !st_r.ctrl[0] |=> $stable(posDemand))
    else $error("demand moved outside position mode");
  // Gear index follows the two select levels
  a_gear_pick: assert property (@(posedge clk) disable iff (rst)
    ##1 gearIndex == $past({gearMsb, gearLsb}))
    else $error("wrong gear numerator index");
  // Mapped select level drives the channel
  a_chan_mapped: assert property (@(posedge clk) disable iff (rst)
    st_r.ctrl[1] |=> lowSpeedSel == $past(chanSelIn))
    else $error("mapped select did not set channel");
  // Mapped select high picks the low-speed channel
  a_chan_low: assert property (@(posedge clk) disable iff (rst)
    (st_r.ctrl[1] && chanSelIn) |=> lowSpeedSel)
    else $error("select high did not pick low-speed channel");
  // Mapped select low picks the high-speed channel
  a_chan_high: assert property (@(posedge clk) disable iff (rst)
    (st_r.ctrl[1] && !chanSelIn) |=> !lowSpeedSel)
    else $error("select low did not pick high-speed channel");
  // Unmapped, the static choice applies
  a_chan_static: assert property (@(posedge clk) disable iff (rst)
    !st_r.ctrl[1] |=> lowSpeedSel == $past(st_r.ctrl[2]))
    else $error("static channel choice not applied");
  // Forward pulse at unity ratio adds one
  a_pulse_take: assert property (@(posedge clk) disable iff (rst)
    (st_r.ctrl[0] && !pulseCmdBlock && pulseStb && !pulseDir && st_r.den == 16'h0001
     && curNum == 16'h0001) |=> posDemand == $past(posDemand) + 32'h1)
    else $error("accepted pulse did not advance demand");
  // Reverse pulse at unity ratio takes one
  a_pulse_back: assert property (@(posedge clk) disable iff (rst)
    (st_r.ctrl[0] && !pulseCmdBlock && pulseStb && pulseDir && st_r.den == 16'h0001
     && curNum == 16'h0001) |=> posDemand == $past(posDemand) - 32'h1)
    else $error("accepted reverse pulse did not lower demand");
  // Ack is a single-cycle pulse
  a_bus_ack: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  // Ack only answers a request
  a_bus_req: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without a request");

endmodule : drive_input_function_select

// File: rtl/dinsel_pkg.sv
// Package for the discrete input function select block.
// Assumes one 100 MHz clock and a classic Wishbone register port.
package dinsel_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_OFS   = 8'h00;  // Mode, map enable, static channel, method
  localparam logic [7:0] MAP_OFS    = 8'h04;  // Input number for each function
  localparam logic [7:0] NUM0_OFS   = 8'h08;  // First gear numerator
  localparam logic [7:0] NUM1_OFS   = 8'h0c;  // Second gear numerator
  localparam logic [7:0] NUM2_OFS   = 8'h10;  // Third gear numerator
  localparam logic [7:0] NUM3_OFS   = 8'h14;  // Fourth gear numerator
  localparam logic [7:0] DEN_OFS    = 8'h18;  // Gear denominator
  localparam logic [7:0] STAT_OFS   = 8'h1c;  // Live status
  localparam logic [7:0] DEMAND_OFS = 8'h20;  // Position demand
  localparam logic [7:0] HCOUNT_OFS = 8'h24;  // Homing start count
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_POSMODE  = 0;   // Position mode active
  localparam int CTRL_SELMAP   = 1;   // Channel select mapped to an input
  localparam int CTRL_STATCH   = 2;   // Static channel: 0 high-speed, 1 low-speed
  localparam int CTRL_METHOD   = 4;   // Homing method, 4 bits
  localparam int MAP_CHSEL     = 0;   // Input index for channel select, 4 bits
  localparam int MAP_GEAR0     = 4;   // Input index for gear lsb
  localparam int MAP_GEAR1     = 8;   // Input index for gear msb
  localparam int MAP_BLOCK     = 12;  // Input index for pulse block
  localparam int MAP_HOME      = 16;  // Input index for homing trigger
  localparam int NUM_INPUTS    = 9;   // General inputs, first through ninth
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  CTRL_RST = 8'h01;      // Position mode, no mapping
  localparam logic [19:0] MAP_RST  = 20'h10320;  // Home I2, block I1, gear I3/I4, sel I1
  localparam logic [15:0] NUM_RST  = 16'h0001;   // Unity numerators
  localparam logic [15:0] DEN_RST  = 16'h0001;   // Unity denominator
endpackage : dinsel_pkg

// File: dv/host_model.sv
// Host controller model: drives the general inputs and both pulse channels.
// Assumes the bench calls its tasks from one process, in step with clk.
`timescale 1ns/10ps
module host_model (
  input  wire logic       clk,        // Drive clock
  output logic      [8:0] genInputs,  // Input levels, bit 0 is I1
  output logic            hsPulse,    // High-speed strobe
  output logic            hsDir,      // High-speed direction
  output logic            lsPulse,    // Low-speed strobe
  output logic            lsDir       // Low-speed direction
);
  // Idle levels at time zero
  initial begin
    genInputs = 9'h000;
    hsPulse   = 1'b0;
    hsDir     = 1'b0;
    lsPulse   = 1'b0;
    lsDir     = 1'b0;
  end
  // Levels move only between bursts, so no move sees a select change
  task automatic set_in(input int idx, input logic v);
    @(posedge clk);
    genInputs[idx] <= v;
  endtask : set_in
  // One-cycle strobes with an idle cycle between them
  task automatic burst(input logic low, input logic dir, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      hsPulse <= !low;
      lsPulse <= low;
      hsDir   <= dir;
      lsDir   <= dir;
      @(posedge clk);
      hsPulse <= 1'b0;
      lsPulse <= 1'b0;
    end
  endtask : burst
endmodule : host_model

// File: dv/tb.sv
// Bench for the input function select block: Wishbone tasks plus a host model.
// Assumes a 100 MHz clock and the register map of the package.
`timescale 1ns/10ps
module tb;
  logic        clk, rst, cyc, stb, we;       // Clock, reset, bus control
  logic [7:0]  adr;                          // Bus address
  logic [31:0] datW, q, expDem;              // Write data, read data, demand
  logic [31:0] datR, posDemand;              // Design outputs
  logic [8:0]  genInputs;                    // Host input levels
  logic [3:0]  homeMethod;                   // Launched method
  logic [1:0]  gearIndex;                    // Chosen numerator
  logic        ack, homeStart, lowSpeedSel;  // Design flags
  logic        hsPulse, hsDir, lsPulse, lsDir;
  int          fails, checked, k;            // Counters
  host_model host (.clk(clk), .genInputs(genInputs), .hsPulse(hsPulse), .hsDir(hsDir),
    .lsPulse(lsPulse), .lsDir(lsDir));
  drive_input_function_select DUT (.clk(clk), .rst(rst), .genInputs(genInputs),
    .hsPulse(hsPulse), .hsDir(hsDir), .lsPulse(lsPulse), .lsDir(lsDir), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(datW),
    .wb_dat_o(datR), .wb_ack_o(ack), .homeStart(homeStart), .homeMethod(homeMethod),
    .lowSpeedSel(lowSpeedSel), .gearIndex(gearIndex), .posDemand(posDemand));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ********************
  // Shared tasks
  // ********************
  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle, held until ack is sampled; bounded wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, datW} <= {1'b1, 1'b1, w, a, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      end_sim();
    end
    q = datR;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle
  // Counts launch strobes seen over n edges
  task automatic homes(input int n);
    k = 0;
    repeat (n) begin
      @(posedge clk);
      if (homeStart === 1'b1) k++;
    end
  endtask : homes
  // ********************
  // Main sequence
  // ********************
  initial begin
    {rst, cyc, stb, we, adr, datW, fails, checked, expDem} = '0;
    rst = 1'b1;
    settle(8);
    rst <= 1'b0;
    wb(0, 8'h00, 0); chk(q, 32'h01);
    wb(0, 8'h04, 0); chk(q, 32'h10320);
    wb(0, 8'h3c, 0); chk(q, 32'h0); // Unmapped offset reads zero
    $display("test reset done");
    // Select on I9, gear on I2/I3, block on I4, home on I5
    wb(1, 8'h04, 32'h43218);
    wb(1, 8'h00, 32'h57); // Map on, static low-speed, method 5
    wb(1, 8'h0c, 32'h2);
    for (int g = 0; g < 4; g++) begin
      host.set_in(1, g[0]);
      host.set_in(2, g[1]);
      settle(3);
      chk(32'(gearIndex), 32'(g));
    end
    host.set_in(1, 1'b0);
    host.set_in(2, 1'b0);
    settle(3);
    $display("test gear done");
    chk(32'(lowSpeedSel), 32'h0);
    host.burst(0, 0, 3);
    expDem += 3;
    host.burst(1, 0, 2);
    settle(3);
    chk(posDemand, expDem);
    host.set_in(3, 1'b1);
    host.burst(0, 0, 3);
    settle(3);
    chk(posDemand, expDem);
    host.set_in(3, 1'b0);
    host.set_in(8, 1'b1);
    settle(3);
    chk(32'(lowSpeedSel), 32'h1);
    host.burst(1, 0, 2);
    expDem += 2;
    host.burst(0, 0, 2);
    settle(3);
    chk(posDemand, expDem);
    host.set_in(8, 1'b0);
    host.set_in(1, 1'b1);
    settle(3);
    host.burst(0, 1, 1);
    expDem -= 2;
    settle(3);
    chk(posDemand, expDem);
    host.set_in(1, 1'b0);
    host.burst(0, 1, 1);
    expDem -= 1;
    settle(3);
    chk(posDemand, expDem);
    $display("test pulses done");
    host.set_in(4, 1'b1);
    homes(8); chk(32'(k), 32'h1);
    chk(32'(homeMethod), 32'h5);
    homes(20); chk(32'(k), 32'h0);
    host.set_in(4, 1'b0);
    wb(1, 8'h00, 32'h97);
    host.set_in(4, 1'b1);
    homes(8); chk(32'(k), 32'h1);
    chk(32'(homeMethod), 32'h9);
    wb(0, 8'h24, 0); chk(q, 32'h2);
    wb(0, 8'h20, 0); chk(q, expDem);
    $display("test homing done");
    wb(1, 8'h00, 32'h05); // Map off, static low-speed
    settle(3);
    chk(32'(lowSpeedSel), 32'h1);
    wb(1, 8'h00, 32'h00); // Position mode off, static high-speed
    host.burst(0, 0, 2);
    settle(3);
    chk(posDemand, expDem);
    chk(32'(lowSpeedSel), 32'h0);
    $display("test static done");
    end_sim();
  end
endmodule : tb
